// ### rtl/dtc_chains.sv
`timescale 1ns/1ns
`include "dtc_regs.svh"

// Overview of operation
// - Instruction chain: 32-bit instruction field plus read-only completion bit.
// - Completion flag clears on issue and sets when the instruction finishes.
// - Run-Test/Idle issues only if halted, enabled, selected, test op, ready, no abort.
// - Update-DR loads instruction only with instruction chain, EXTEST and ready.
// - Ready is completion sampled at Capture-DR; gates issue and instruction load.
// - Debug-issued instructions never increment the program counter.
// - Instruction register is write-only; capture loads a fill value.
// - Data chain is 34 bits: two flags then a 32-bit word.
// - INTEST selects outbound data, EXTEST selects inbound data.
// - Capture samples retry from inbound-empty, valid from outbound-full, ready.
// - Inbound goes debugger to core, outbound goes core to debugger.
// - Outbound-full sets on core write, clears at capture under INTEST only.
// - Inbound-empty clears on debugger write, sets when core reads.
// - Enable clear: retry sampled clear blocks the next inbound update.
// - Enable clear: completion reads set, abort flag unspecified.
// - Enable set: ready sampled clear blocks the next inbound update.
// - Enable set: precise data abort sets the sticky abort flag.
// - State changes and enabling leave data and flags untouched.
// - EXTEST updates at Update-DR; INTEST never updates, clears read-to-clear bits.
module dtc_chains (
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic tck,
    input wire logic tdi,
    output logic tdo,
    input wire logic tapCaptureDr,
    input wire logic tapShiftDr,
    input wire logic tapUpdateDr,
    input wire logic tapRunIdle,
    input wire logic [4:0] chainSel,
    input wire logic intestActive,
    input wire logic extestActive,
    input wire logic coreHalted,
    input wire logic execEnable,
    input wire logic preciseAbort,
    input wire logic abortClear,
    output logic abortSticky,
    output logic issueValid,
    output logic [31:0] issueInstr,
    output logic issueHoldPc,
    input wire logic instrDone,
    input wire logic coreWrValid,
    input wire logic [31:0] coreWrData,
    input wire logic coreRdAck,
    output logic [31:0] inboundData,
    output logic inboundEmpty,
    output logic outboundFull,
    output logic instrComplete
);

    // ============================================================
    // Domain state and crossings
    dtc_pkg::dtc_tck_state_t tck_ff;
    dtc_pkg::dtc_tck_state_t nxt_tck;
    dtc_pkg::dtc_sys_state_t sys_ff;
    dtc_pkg::dtc_sys_state_t nxt_sys;
    dtc_pkg::dtc_event_t evSync;
    dtc_pkg::dtc_feedback_t fbSend;
    dtc_pkg::dtc_feedback_t fbSync;

    // Toggles from the test side into the system side
    dtc_sync #(
        .WIDTH($bits(dtc_pkg::dtc_event_t))
    ) u_evSync (
        .clk(sys_clk),
        .reset(reset),
        .d(tck_ff.ev),
        .q(evSync)
    );

    // Flags, core levels and echoes back into the test side
    assign fbSend = '{halted: coreHalted, execEn: execEnable, complete: sys_ff.complete,
                      inEmpty: sys_ff.inEmpty, outFull: sys_ff.outFull,
                      abort: sys_ff.abort, echo: sys_ff.echo};

    dtc_sync #(
        .WIDTH($bits(dtc_pkg::dtc_feedback_t))
    ) u_fbSync (
        .clk(tck),
        .reset(reset),
        .d(fbSend),
        .q(fbSync)
    );

    // ============================================================
    // Test-clock side helpers
    logic selInstr;
    logic selData;
    logic testOp;
    logic complSeen;
    logic emptySeen;
    logic fullSeen;
    logic runIdleEntry;
    logic issueOk;
    logic inUpdateOk;

    assign selInstr = (chainSel == `DTC_CHAIN_INSTR);
    assign selData = (chainSel == `DTC_CHAIN_DATA);
    assign testOp = intestActive | extestActive;

    // A flag is trusted only once the system side has echoed our last event;
    // otherwise a quick second capture would read a stale flag
    assign complSeen = fbSync.complete & (tck_ff.ev.issueTgl == fbSync.echo.issueTgl);
    assign emptySeen = fbSync.inEmpty & (tck_ff.ev.wrTgl == fbSync.echo.wrTgl);
    assign fullSeen = fbSync.outFull & (tck_ff.ev.clrTgl == fbSync.echo.clrTgl);

    assign runIdleEntry = tapRunIdle & ~tck_ff.runIdlePrev;

    // Issue gate on entry into Run-Test/Idle
    assign issueOk = fbSync.halted & fbSync.execEn & (selInstr | selData) & testOp
                     & tck_ff.readyCap & ~fbSync.abort;

    // Overwrite protection picks its flag from execute-enable
    assign inUpdateOk = fbSync.execEn ? tck_ff.readyCap : tck_ff.retryCap;

    // ============================================================
    // Test-clock side next state
    always_comb
    begin
        nxt_tck = tck_ff;
        nxt_tck.runIdlePrev = tapRunIdle;
        if (tapCaptureDr && (selInstr || selData))
        begin
            nxt_tck.readyCap = complSeen;
        end
        if (tapCaptureDr && selInstr)
        begin
            // Instruction field is write-only, so a fill value is captured
            nxt_tck.shift = {1'b0, `DTC_INSTR_CAPTURE_FILL, complSeen};
        end
        else if (tapCaptureDr && selData)
        begin
            nxt_tck.retryCap = emptySeen;
            if (intestActive)
            begin
                // Outbound word is captured; only INTEST empties it
                nxt_tck.shift = {sys_ff.outData, fullSeen, complSeen};
                nxt_tck.ev.clrTgl = ~tck_ff.ev.clrTgl;
            end
            else
            begin
                // EXTEST still captures the outbound word but leaves its flag alone
                nxt_tck.shift = {sys_ff.outData, emptySeen, complSeen};
            end
        end
        else if (tapShiftDr && selInstr)
        begin
            nxt_tck.shift = {1'b0, tdi, tck_ff.shift[32:1]};
        end
        else if (tapShiftDr && selData)
        begin
            nxt_tck.shift = {tdi, tck_ff.shift[33:1]};
        end
        else if (tapUpdateDr && extestActive && selInstr && tck_ff.readyCap)
        begin
            nxt_tck.instr = tck_ff.shift[32:1];
        end
        else if (tapUpdateDr && extestActive && selData && inUpdateOk)
        begin
            // Debugger write into the inbound register
            nxt_tck.inData = tck_ff.shift[33:2];
            nxt_tck.ev.wrTgl = ~tck_ff.ev.wrTgl;
        end
        if (runIdleEntry && issueOk)
        begin
            nxt_tck.ev.issueTgl = ~tck_ff.ev.issueTgl;
        end
    end

    always_ff @(posedge tck or posedge reset)
    begin
        if (reset)
        begin
            tck_ff <= '{shift: `DTC_SHIFT_RESET, instr: `DTC_WORD_RESET,
                        inData: `DTC_WORD_RESET, readyCap: 1'b0, retryCap: 1'b0,
                        runIdlePrev: 1'b0, ev: '0};
        end
        else
        begin
            tck_ff <= nxt_tck;
        end
    end

    assign tdo = tck_ff.shift[`DTC_READY_BIT];

    // ============================================================
    // System side event arrivals
    logic arrIssue;
    logic arrWr;
    logic arrClr;

    assign arrIssue = evSync.issueTgl ^ sys_ff.echo.issueTgl;
    assign arrWr = evSync.wrTgl ^ sys_ff.echo.wrTgl;
    assign arrClr = evSync.clrTgl ^ sys_ff.echo.clrTgl;

    // ============================================================
    // System side next state; words from the test side are copied only
    // after their toggle has crossed, so they are already stable
    always_comb
    begin
        nxt_sys = sys_ff;
        nxt_sys.echo = evSync;
        nxt_sys.issueValid = arrIssue;
        if (arrIssue)
        begin
            nxt_sys.issueInstr = tck_ff.instr;
            nxt_sys.complete = 1'b0;
        end
        if (instrDone)
        begin
            nxt_sys.complete = 1'b1;
        end
        if (!execEnable)
        begin
            nxt_sys.complete = 1'b1;
        end
        if (coreRdAck)
        begin
            nxt_sys.inEmpty = 1'b1;
        end
        if (arrWr)
        begin
            // A fresh word beats a read of the old one
            nxt_sys.inData = tck_ff.inData;
            nxt_sys.inEmpty = 1'b0;
        end
        if (arrClr)
        begin
            nxt_sys.outFull = 1'b0;
        end
        if (coreWrValid)
        begin
            nxt_sys.outData = coreWrData;
            nxt_sys.outFull = 1'b1;
        end
        if (abortClear)
        begin
            nxt_sys.abort = 1'b0;
        end
        if (execEnable && preciseAbort)
        begin
            nxt_sys.abort = 1'b1;
        end
        // Nothing here watches halt or enable edges, so entering or leaving
        // debug state disturbs no register or flag
    end

    always_ff @(posedge sys_clk or posedge reset)
    begin
        if (reset)
        begin
            sys_ff <= '{outData: `DTC_WORD_RESET, inData: `DTC_WORD_RESET,
                        issueInstr: `DTC_WORD_RESET, issueValid: 1'b0,
                        complete: 1'b1, inEmpty: 1'b1, outFull: 1'b0,
                        abort: 1'b0, echo: '0};
        end
        else
        begin
            sys_ff <= nxt_sys;
        end
    end

    // ============================================================
    // Core-facing outputs
    assign issueValid = sys_ff.issueValid;
    assign issueInstr = sys_ff.issueInstr;
    // Prefetch keeps the counter still for every debug-issued instruction
    assign issueHoldPc = sys_ff.issueValid;
    assign inboundData = sys_ff.inData;
    assign inboundEmpty = sys_ff.inEmpty;
    assign outboundFull = sys_ff.outFull;
    assign instrComplete = sys_ff.complete;
    assign abortSticky = sys_ff.abort;

    // ============================================================
    // Checks, system side
    property p_issue_clears;
        @(posedge sys_clk) disable iff (reset)
        issueValid && $past(execEnable) && !$past(instrDone) |-> !instrComplete;
    endproperty
    a_issue_clears: assert property (p_issue_clears)
        else $error("completion flag not cleared on issue");

    property p_done_sets;
        @(posedge sys_clk) disable iff (reset)
        instrDone |=> instrComplete;
    endproperty
    a_done_sets: assert property (p_done_sets)
        else $error("completion flag not set after done");

    property p_ee_clear_complete;
        @(posedge sys_clk) disable iff (reset)
        !execEnable [*2] |-> instrComplete;
    endproperty
    a_ee_clear_complete: assert property (p_ee_clear_complete)
        else $error("completion flag clear while execute-enable clear");

    property p_wr_sets_full;
        @(posedge sys_clk) disable iff (reset)
        coreWrValid |=> outboundFull && (outboundFull == 1'b1);
    endproperty
    a_wr_sets_full: assert property (p_wr_sets_full)
        else $error("outbound full not set by core write");

    property p_rd_sets_empty;
        @(posedge sys_clk) disable iff (reset)
        coreRdAck && !arrWr |=> inboundEmpty;
    endproperty
    a_rd_sets_empty: assert property (p_rd_sets_empty)
        else $error("inbound empty not set by core read");

    property p_abort_sets;
        @(posedge sys_clk) disable iff (reset)
        execEnable && preciseAbort |=> abortSticky;
    endproperty
    a_abort_sets: assert property (p_abort_sets)
        else $error("sticky abort not set");

    property p_abort_holds;
        @(posedge sys_clk) disable iff (reset)
        abortSticky && !abortClear |=> abortSticky;
    endproperty
    a_abort_holds: assert property (p_abort_holds)
        else $error("sticky abort dropped without clear");

    // ============================================================
    // Checks, test-clock side
    property p_instr_gate;
        @(posedge tck) disable iff (reset)
        tapUpdateDr && !(extestActive && selInstr && tck_ff.readyCap) && !tapCaptureDr
        && !tapShiftDr |=> $stable(tck_ff.instr);
    endproperty
    a_instr_gate: assert property (p_instr_gate)
        else $error("instruction loaded without its conditions");

    property p_no_issue_unready;
        @(posedge tck) disable iff (reset)
        runIdleEntry && !tck_ff.readyCap |=> $stable(tck_ff.ev.issueTgl);
    endproperty
    a_no_issue_unready: assert property (p_no_issue_unready)
        else $error("instruction issued without ready");

    property p_intest_no_update;
        @(posedge tck) disable iff (reset)
        tapUpdateDr && !extestActive |=> $stable(tck_ff.inData);
    endproperty
    a_intest_no_update: assert property (p_intest_no_update)
        else $error("inbound updated without EXTEST");

endmodule : dtc_chains

// ### rtl/dtc_pkg.sv
package dtc_pkg;

    // ============================================================
    // Events sent from the test-clock side as toggles
    typedef struct packed {
        logic issueTgl;
        logic wrTgl;
        logic clrTgl;
    } dtc_event_t;

    // ============================================================
    // Levels fed back from the system side to the test-clock side
    typedef struct packed {
        logic halted;
        logic execEn;
        logic complete;
        logic inEmpty;
        logic outFull;
        logic abort;
        dtc_event_t echo;
    } dtc_feedback_t;

    // ============================================================
    // Test-clock domain state
    typedef struct packed {
        logic [33:0] shift;
        logic [31:0] instr;
        logic [31:0] inData;
        logic readyCap;
        logic retryCap;
        logic runIdlePrev;
        dtc_event_t ev;
    } dtc_tck_state_t;

    // ============================================================
    // System clock domain state
    typedef struct packed {
        logic [31:0] outData;
        logic [31:0] inData;
        logic [31:0] issueInstr;
        logic issueValid;
        logic complete;
        logic inEmpty;
        logic outFull;
        logic abort;
        dtc_event_t echo;
    } dtc_sys_state_t;

endpackage : dtc_pkg

// ### rtl/dtc_regs.svh
`ifndef DTC_REGS_SVH
`define DTC_REGS_SVH

// ============================================================
// Chain numbers as loaded into the chain-select register
`define DTC_CHAIN_INSTR 5'h04
`define DTC_CHAIN_DATA 5'h05

// ============================================================
// Chain lengths and field positions
`define DTC_INSTR_LEN 33
`define DTC_DATA_LEN 34
`define DTC_READY_BIT 0
`define DTC_FLAG_BIT 1

// ============================================================
// Fill value for the write-only instruction field at capture
`define DTC_INSTR_CAPTURE_FILL 32'h00000000

// ============================================================
// Reset values
`define DTC_WORD_RESET 32'h00000000
`define DTC_SHIFT_RESET 34'h000000000

`endif

// ### rtl/dtc_sync.sv
`timescale 1ns/1ns

// Two-flop level synchroniser; the first stage feeds only the second
module dtc_sync #(
    parameter int WIDTH = 1
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic [WIDTH-1:0] d,
    output logic [WIDTH-1:0] q
);

    typedef struct packed {
        logic [WIDTH-1:0] meta;
        logic [WIDTH-1:0] hold;
    } dtc_sync_state_t;

    dtc_sync_state_t st_ff;
    dtc_sync_state_t nxt_st;

    // Shift the level through both stages
    always_comb
    begin
        nxt_st.meta = d;
        nxt_st.hold = st_ff.meta;
    end

    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            st_ff <= '0;
        end
        else
        begin
            st_ff <= nxt_st;
        end
    end

    assign q = st_ff.hold;

endmodule : dtc_sync

// ### tb/dtc_debugger_model.sv
`timescale 1ns/1ns
`include "dtc_regs.svh"

// External scan debugger: owns the test clock and walks the DR leg
module dtc_debugger_model (
    output logic tck,
    output logic tdi,
    input wire logic tdo,
    output logic tapCaptureDr,
    output logic tapShiftDr,
    output logic tapUpdateDr,
    output logic tapRunIdle,
    output logic [4:0] chainSel,
    output logic intestActive,
    output logic extestActive
);
    logic tckEn;

    // ============================================================
    // Test clock, 15 ns, stands low between frames
    initial
    begin
        tck = 1'b0;
        forever
        begin
            #8 tck = tckEn;
            #7 tck = 1'b0;
        end
    end

    // Runs through reset so the synchronisers flush before the first frame
    initial
    begin
        tckEn = 1'b1;
        tdi = 1'b0;
        tapCaptureDr = 1'b0;
        tapShiftDr = 1'b0;
        tapUpdateDr = 1'b0;
        tapRunIdle = 1'b0;
        chainSel = `DTC_CHAIN_INSTR;
        intestActive = 1'b0;
        extestActive = 1'b1;
    end

    // ============================================================
    // One DR frame: capture, shift LSB first, update, optional idle pass
    task automatic scan(input logic [4:0] ch, input logic inTest, input logic [33:0] din,
                        input logic goIdle, output logic [33:0] dout);
        int len;
        len = (ch == `DTC_CHAIN_INSTR) ? `DTC_INSTR_LEN : `DTC_DATA_LEN;
        dout = '0;
        tckEn = 1'b1;
        @(posedge tck);
        chainSel <= ch;
        intestActive <= inTest;
        extestActive <= !inTest;
        // Settle time lets feedback flags cross before capture
        repeat (4) @(posedge tck);
        tapCaptureDr <= 1'b1;
        @(posedge tck);
        tapCaptureDr <= 1'b0;
        tapShiftDr <= 1'b1;
        tdi <= din[0];
        for (int i = 0; i < len; i++)
        begin
            @(posedge tck);
            dout[i] = tdo;
            // Released line shows the inverse, never a stale bit
            tdi <= (i + 1 < len) ? din[i + 1] : ~din[i];
        end
        tapShiftDr <= 1'b0;
        tapUpdateDr <= 1'b1;
        @(posedge tck);
        tapUpdateDr <= 1'b0;
        tapRunIdle <= goIdle;
        @(posedge tck);
        tapRunIdle <= 1'b0;
        repeat (8) @(posedge tck);
        tckEn = 1'b0;
    endtask : scan
endmodule : dtc_debugger_model

// ### tb/tb_debug_instr_data_transfer_chains.sv
`timescale 1ns/1ns
`include "dtc_regs.svh"

`define CHK(act, exp) \
    begin \
        checks_done++; \
        if ((act) !== (exp)) \
        begin \
            miscompares++; \
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (act), (exp)); \
        end \
    end

module tb_debug_instr_data_transfer_chains;
    localparam int EV_WR = 0;
    localparam int EV_RD = 1;
    localparam int EV_DONE = 2;
    localparam int EV_ABORT = 3;
    localparam int EV_CLR = 4;
    localparam logic [4:0] CI = `DTC_CHAIN_INSTR;
    localparam logic [4:0] CD = `DTC_CHAIN_DATA;
    localparam logic [31:0] W1 = 32'hA5C30F96;
    localparam logic [31:0] D1 = 32'h1234ABCD;
    localparam logic [31:0] D2 = 32'h0F0FF0F0;
    localparam logic [31:0] D3 = 32'h55AA33CC;
    localparam logic [31:0] I1 = 32'h13579BDF;
    localparam logic [31:0] I2 = 32'h2468ACE0;
    localparam logic [31:0] I3 = 32'h76543210;

    logic sys_clk = 1'b0;
    logic reset;
    logic tck, tdi, tdo, tapCaptureDr, tapShiftDr, tapUpdateDr, tapRunIdle;
    logic [4:0] chainSel;
    logic intestActive, extestActive, coreHalted, execEnable, preciseAbort, abortClear;
    logic abortSticky, issueValid, issueHoldPc, instrDone, coreWrValid, coreRdAck;
    logic inboundEmpty, outboundFull, instrComplete, lastHold;
    logic [31:0] issueInstr, coreWrData, inboundData, lastInstr;
    logic [33:0] so;
    int miscompares = 0;
    int checks_done = 0;
    int issueCnt = 0;

    // ============================================================
    // Clock, design and far-side debugger
    always #5 sys_clk = ~sys_clk;

    dtc_chains DUT (.sys_clk(sys_clk), .reset(reset), .tck(tck), .tdi(tdi), .tdo(tdo),
        .tapCaptureDr(tapCaptureDr), .tapShiftDr(tapShiftDr), .tapUpdateDr(tapUpdateDr),
        .tapRunIdle(tapRunIdle), .chainSel(chainSel), .intestActive(intestActive),
        .extestActive(extestActive), .coreHalted(coreHalted), .execEnable(execEnable),
        .preciseAbort(preciseAbort), .abortClear(abortClear), .abortSticky(abortSticky),
        .issueValid(issueValid), .issueInstr(issueInstr), .issueHoldPc(issueHoldPc),
        .instrDone(instrDone), .coreWrValid(coreWrValid), .coreWrData(coreWrData),
        .coreRdAck(coreRdAck), .inboundData(inboundData), .inboundEmpty(inboundEmpty),
        .outboundFull(outboundFull), .instrComplete(instrComplete));

    dtc_debugger_model dbg (.tck(tck), .tdi(tdi), .tdo(tdo), .tapCaptureDr(tapCaptureDr),
        .tapShiftDr(tapShiftDr), .tapUpdateDr(tapUpdateDr), .tapRunIdle(tapRunIdle),
        .chainSel(chainSel), .intestActive(intestActive), .extestActive(extestActive));

    // Issue pulses last one cycle, so they are logged at every edge
    always @(posedge sys_clk)
    begin
        if (issueValid === 1'b1)
        begin
            issueCnt++;
            lastInstr = issueInstr;
            lastHold = issueHoldPc;
        end
    end

    // ============================================================
    // Core-side pulses and debug-state levels
    task automatic core_event(input int kind, input logic [31:0] d);
        @(posedge sys_clk);
        case (kind)
            EV_WR: coreWrValid <= 1'b1;
            EV_RD: coreRdAck <= 1'b1;
            EV_DONE: instrDone <= 1'b1;
            EV_ABORT: preciseAbort <= 1'b1;
            default: abortClear <= 1'b1;
        endcase
        coreWrData <= d;
        @(posedge sys_clk);
        coreWrValid <= 1'b0;
        coreRdAck <= 1'b0;
        instrDone <= 1'b0;
        preciseAbort <= 1'b0;
        abortClear <= 1'b0;
        coreWrData <= ~d;
        repeat (2) @(posedge sys_clk);
    endtask : core_event

    task automatic set_levels(input logic h, input logic e);
        @(posedge sys_clk);
        coreHalted <= h;
        execEnable <= e;
        repeat (3) @(posedge sys_clk);
    endtask : set_levels

    // Bounded wait; a missing or extra issue shows as a count mismatch
    task automatic expect_issues(input int n);
        for (int i = 0; i < 40 && issueCnt != n; i++)
            @(posedge sys_clk);
        `CHK(issueCnt, n)
    endtask : expect_issues

    task automatic test_done;
        $display("checks_done=%0d miscompares=%0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : test_done

    // ============================================================
    // Watchdog: the whole sequence needs well under 40 us
    initial
    begin
        #200000;
        miscompares++;
        $display("watchdog expired");
        test_done();
    end

    // ============================================================
    // Test sequence
    initial
    begin
        reset = 1'b1;
        {coreHalted, execEnable, preciseAbort, abortClear} = 4'h0;
        {instrDone, coreWrValid, coreRdAck} = 3'h0;
        coreWrData = 32'h00000000;
        repeat (6) @(posedge sys_clk);
        reset <= 1'b0;
        repeat (3) @(posedge sys_clk);
        `CHK({issueValid, inboundEmpty, outboundFull, instrComplete, abortSticky}, 5'h0A)
        `CHK(inboundData, `DTC_WORD_RESET)
        $display("test reset done");
        // Data chain with execute-enable clear
        core_event(EV_WR, W1);
        `CHK(outboundFull, 1'b1)
        dbg.scan(CD, 1'b0, {D1, 2'b00}, 1'b0, so);
        `CHK(so[33:2], W1)
        `CHK(so[1], 1'b1)
        `CHK(so[0], 1'b1)
        `CHK(outboundFull, 1'b1)
        `CHK(inboundData, D1)
        `CHK(inboundEmpty, 1'b0)
        dbg.scan(CD, 1'b0, {D2, 2'b00}, 1'b0, so);
        `CHK(so[1], 1'b0)
        `CHK(inboundData, D1)
        dbg.scan(CD, 1'b1, {D2, 2'b00}, 1'b0, so);
        `CHK(so[33:2], W1)
        `CHK(so[1], 1'b1)
        `CHK(outboundFull, 1'b0)
        `CHK(inboundData, D1)
        core_event(EV_RD, 32'h00000000);
        `CHK(inboundEmpty, 1'b1)
        $display("test data_chain done");
        // Halt, then enable execution; nothing may move
        set_levels(1'b1, 1'b0);
        set_levels(1'b1, 1'b1);
        `CHK({inboundEmpty, outboundFull, instrComplete}, 3'h5)
        `CHK(inboundData, D1)
        dbg.scan(CI, 1'b0, {1'b0, I1, 1'b0}, 1'b0, so);
        `CHK(so[32:1], `DTC_INSTR_CAPTURE_FILL)
        `CHK(so[0], 1'b1)
        expect_issues(0);
        dbg.scan(CD, 1'b0, {D2, 2'b00}, 1'b1, so);
        `CHK(inboundData, D2)
        expect_issues(1);
        `CHK(lastInstr, I1)
        `CHK(lastHold, 1'b1)
        `CHK(instrComplete, 1'b0)
        // Busy core: ready captured clear refuses load, issue and inbound write
        dbg.scan(CI, 1'b0, {1'b0, I2, 1'b0}, 1'b1, so);
        `CHK(so[0], 1'b0)
        expect_issues(1);
        core_event(EV_RD, 32'h00000000);
        dbg.scan(CD, 1'b0, {D3, 2'b00}, 1'b0, so);
        `CHK(inboundData, D2)
        core_event(EV_DONE, 32'h00000000);
        `CHK(instrComplete, 1'b1)
        dbg.scan(CI, 1'b1, {1'b0, I2, 1'b0}, 1'b1, so);
        `CHK(so[0], 1'b1)
        expect_issues(2);
        `CHK(lastInstr, I1)
        core_event(EV_DONE, 32'h00000000);
        $display("test issue done");
        // Sticky abort blocks issue until cleared
        core_event(EV_ABORT, 32'h00000000);
        `CHK(abortSticky, 1'b1)
        dbg.scan(CD, 1'b1, 34'h000000000, 1'b1, so);
        expect_issues(2);
        core_event(EV_CLR, 32'h00000000);
        `CHK(abortSticky, 1'b0)
        // Load while disabled, issue once enabled again
        set_levels(1'b1, 1'b0);
        dbg.scan(CI, 1'b0, {1'b0, I3, 1'b0}, 1'b1, so);
        expect_issues(2);
        `CHK(instrComplete, 1'b1)
        set_levels(1'b1, 1'b1);
        dbg.scan(CI, 1'b1, 34'h000000000, 1'b1, so);
        expect_issues(3);
        `CHK(lastInstr, I3)
        core_event(EV_DONE, 32'h00000000);
        set_levels(1'b1, 1'b0);
        $display("test abort_enable done");
        test_done();
    end
endmodule : tb_debug_instr_data_transfer_chains
